// ==== acsi_pkg.sv ====
// Package for the async channel status and interrupt block.
// Assumes one 200 MHz system clock shared by every user of these constants.
package acsi_pkg;
   // Register indices on the plain register port
   localparam logic [2:0] ADDR_STATUS  = 3'h0;  // read main_status_reg, write command_pointer_reg
   localparam logic [2:0] ADDR_SPECIAL = 3'h1;  // read special_receive_status_reg, write interrupt_mode_reg
   localparam logic [2:0] ADDR_VECTOR  = 3'h2;  // read vector_readback_reg, write vector_base_reg
   localparam logic [2:0] ADDR_DATA    = 3'h3;  // read receive data, write transmit data
   localparam logic [2:0] ADDR_CTRL    = 3'h4;  // receive / transmit / auto enables
   // main_status_reg bits
   localparam int ST_RX_AVAIL = 0;
   localparam int ST_INT_PEND = 1;
   localparam int ST_TX_EMPTY = 2;
   localparam int ST_CARRIER  = 3;
   localparam int ST_SYNC     = 4;
   localparam int ST_CTS      = 5;
   localparam int ST_BREAK    = 7;
   // special_receive_status_reg bits
   localparam int SR_ALL_SENT = 0;
   localparam int SR_PARITY   = 4;
   localparam int SR_OVERRUN  = 5;
   localparam int SR_FRAMING  = 6;
   // interrupt_mode_reg bits
   localparam int IM_EXT_EN   = 0;
   localparam int IM_TX_EN    = 1;
   localparam int IM_SAV      = 2;
   localparam int IM_RX_LO    = 3;
   // Control register bits
   localparam int CT_RX_EN    = 0;
   localparam int CT_TX_EN    = 1;
   localparam int CT_AUTO     = 2;
   // Command field of command_pointer_reg
   localparam int CMD_LO = 3;
   localparam logic [2:0] CMD_RESET_EXT   = 3'h2;
   localparam logic [2:0] CMD_CHAN_RESET  = 3'h3;
   localparam logic [2:0] CMD_RESET_TXP   = 3'h5;
   localparam logic [2:0] CMD_ERROR_RESET = 3'h6;
   // Receive interrupt modes
   typedef enum logic [1:0] {ACSI_RX_OFF, ACSI_RX_FIRST, ACSI_RX_ALL_NOPAR, ACSI_RX_ALL} acsi_rxmode_t;
   // Vector causes, in vector bits 2:1
   localparam logic [1:0] CAUSE_TX      = 2'h0;
   localparam logic [1:0] CAUSE_EXT     = 2'h1;
   localparam logic [1:0] CAUSE_RX      = 2'h2;
   localparam logic [1:0] CAUSE_SPECIAL = 2'h3;
   // Reset values
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [2:0] RST_CTRL   = 3'h0;
   // Timing
   localparam int SYS_CLK_MHZ    = 200;
   localparam int DCD_MIN_NS     = 200;   // least carrier pulse that is reported
   localparam int DCD_MIN_CYCLES = (DCD_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int BREAK_EDGES    = 10;    // link clock edges of low data that make a break
   localparam int RX_DEPTH       = 3;
   // Buffered receive character with its own error flags
   typedef struct packed {
      logic [7:0] data;
      logic       framing;
      logic       overrun;
      logic       parity;
   } acsi_rxent_t;
   // External/status inputs as seen by software
   typedef struct packed {
      logic brk;
      logic cts;
      logic dcd;
      logic sync;
   } acsi_ext_t;
endpackage : acsi_pkg

// ==== acsi_sync.sv ====
// Two-flop synchroniser for pins entering the system clock domain.
// Assumes the inputs are asynchronous levels; first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none
module acsi_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta <= '1;
         q    <= '1;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : acsi_sync
`default_nettype wire

// ==== acsi_channel.sv ====
// Status, receive error buffering and vectored interrupt logic of one async channel.
// Assumes a framer on sys_clk delivers characters, and the second channel feeds sav_in.
// Function
// RULE1: enabled external interrupt sets break bit 7 and requests interrupt on break.
// RULE2: after break report, interrupt again with break bit 0 when break ends.
// RULE3: host resets external/status interrupt after break start and again after end.
// RULE4: carrier inactive longer than minimum width raises external interrupt, carrier bit 0.
// RULE5: carrier status bit reads inverse of active-low carrier pin.
// RULE6: status read after data read shows next buffered character's flags.
// RULE7: first-character mode freezes errored character and flags until error reset.
// RULE8: every-character mode gives a different vector when current character has errors.
// RULE9: overrun overwrites the last buffered character with the newest one.
// RULE10: overwriting character reads with overrun flag and special vector if enabled.
// RULE11: receive-available bit 0 clears once the buffers are read empty.
// RULE12: transmit-empty bit reads 1 whenever transmit buffer is empty.
// RULE13: host polls transmit-empty before writing and receive-available before reading.
// RULE14: status-affects-vector modifies vector by rx, tx, external and special causes.
// RULE15: vector encodes channel and cause giving eight distinct routines.
// RULE16: status-affects-vector set only by second channel, governs both channels.
// RULE17: auto enables gate transmitter by clear-to-send and receiver by carrier.
// RULE18: transmit interrupts arise only when a filled buffer empties.
// RULE19: all-sent bit true only when transmission fully completed.
// RULE20: external interrupt on clear-to-send, carrier, sync changes and break.
// RULE21: acknowledge cycle returns possibly modified vector.
// RULE22: without native acknowledge, external logic reads vector register and returns it.
// RULE23: parity error latches until error reset command.
// RULE24: framing flag only for its character; adds half bit before start search.
// RULE25: three buffered characters, each with flags loaded with the character.
// RULE26: status captures external bits at interrupt until reset-external command.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acsi_channel #(
   parameter bit CHAN_B    = 1'b1,
   parameter int DEPTH     = acsi_pkg::RX_DEPTH,
   parameter int DCD_CYCLES = acsi_pkg::DCD_MIN_CYCLES,
   parameter int BRK_EDGES = acsi_pkg::BREAK_EDGES
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic [2:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [7:0]           reg_rdata,
   input  wire logic                 int_ack,
   output logic      [7:0]           ack_vector,
   output logic                      ack_valid,
   output logic                      int_req,
   input  wire logic                 sav_in,
   output logic                      sav_out,
   input  wire logic                 rx_clk_pin,
   input  wire logic                 rxd_pin,
   input  wire logic                 cts_in_n,
   input  wire logic                 carrier_detect_in_n,
   input  wire logic                 sync_in_n,
   input  wire logic                 rx_char_valid,
   input  wire acsi_pkg::acsi_rxent_t rx_char,
   output logic                      rx_run,
   output logic                      rx_search_hold,
   output logic                      tx_char_valid,
   input  wire logic                 tx_char_ready,
   output logic      [7:0]           tx_char,
   input  wire logic                 tx_shift_busy,
   output logic                      tx_run
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [15:0] DCD_LAST = 16'(DCD_CYCLES - 1);

   logic [4:0]            pins_s;
   logic                  clk_d;
   logic [7:0]            imr;
   logic [7:0]            vbase;
   logic [2:0]            ctrl;
   acsi_pkg::acsi_rxent_t fifo [DEPTH];
   logic [CW-1:0]         cnt;
   logic [CW-1:0]         wr_idx;
   logic                  frozen, frz_rel, par_stk, ovr_stk, first_arm, first_pend;
   logic                  brk_live, dcd_filt, ext_pend, tx_full, tx_pend;
   logic [3:0]            brk_cnt;
   logic [15:0]           dcd_cnt;
   acsi_pkg::acsi_ext_t   ext_live, ext_lat;
   logic                  wr_cmd, cmd_ext, cmd_err, cmd_txp, chan_clr;
   logic                  push, pop, full, handoff, special, rx_int, sav;
   logic                  head_err, lk_rise, lk_fall;
   logic [1:0]            cause;
   logic [7:0]            vector, main_status, special_status;
   acsi_pkg::acsi_rxmode_t rx_mode;

   acsi_sync #(.W(5)) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       ({rx_clk_pin, rxd_pin, cts_in_n, carrier_detect_in_n, sync_in_n}),
      .q       (pins_s)
   );

   // Decoded commands
   assign wr_cmd   = reg_wr && (reg_addr == acsi_pkg::ADDR_STATUS);
   assign cmd_ext  = wr_cmd && (reg_wdata[acsi_pkg::CMD_LO +: 3] == acsi_pkg::CMD_RESET_EXT);
   assign cmd_err  = wr_cmd && (reg_wdata[acsi_pkg::CMD_LO +: 3] == acsi_pkg::CMD_ERROR_RESET);
   assign cmd_txp  = wr_cmd && (reg_wdata[acsi_pkg::CMD_LO +: 3] == acsi_pkg::CMD_RESET_TXP);
   assign chan_clr = rst || (wr_cmd && (reg_wdata[acsi_pkg::CMD_LO +: 3] == acsi_pkg::CMD_CHAN_RESET));
   assign rx_mode  = acsi_pkg::acsi_rxmode_t'(imr[acsi_pkg::IM_RX_LO +: 2]);

   // Software-written configuration
   always_ff @(posedge sys_clk) begin
      if (chan_clr) begin
         imr   <= acsi_pkg::RST_BYTE;
         ctrl  <= acsi_pkg::RST_CTRL;
      end else if (reg_wr) begin
         case (reg_addr)
            acsi_pkg::ADDR_SPECIAL: imr  <= reg_wdata;
            acsi_pkg::ADDR_CTRL:    ctrl <= reg_wdata[2:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) vbase <= acsi_pkg::RST_BYTE;
      else if (reg_wr && reg_addr == acsi_pkg::ADDR_VECTOR) vbase <= reg_wdata;
   end

   // Auto enables
   assign rx_run = ctrl[acsi_pkg::CT_RX_EN] && (!ctrl[acsi_pkg::CT_AUTO] || dcd_filt);   // [RULE17]
   assign tx_run = ctrl[acsi_pkg::CT_TX_EN] && (!ctrl[acsi_pkg::CT_AUTO] || !pins_s[2]); // [RULE17]

   // Link clock edges from the sampled pin
   always_ff @(posedge sys_clk) begin
      if (rst) clk_d <= 1'b1;
      else clk_d <= pins_s[4];
   end
   assign lk_rise = pins_s[4] && !clk_d;
   assign lk_fall = !pins_s[4] && clk_d;

   // Break: data low over several link clock edges, ends on a high sample
   always_ff @(posedge sys_clk) begin
      if (chan_clr) begin
         brk_cnt  <= 4'h0;
         brk_live <= 1'b0;
      end else if (lk_rise) begin
         if (pins_s[3]) begin
            brk_cnt  <= 4'h0;
            brk_live <= 1'b0;                                  // [RULE2]
         end else if (brk_cnt == 4'(BRK_EDGES - 1)) begin
            brk_live <= 1'b1;                                  // [RULE1]
         end else begin
            brk_cnt <= brk_cnt + 4'h1;
         end
      end
   end

   // Framing error holds off start search until the next falling link clock edge
   always_ff @(posedge sys_clk) begin
      if (chan_clr) rx_search_hold <= 1'b0;
      else if (rx_char_valid && rx_run && rx_char.framing) rx_search_hold <= 1'b1;   // [RULE24]
      else if (lk_fall) rx_search_hold <= 1'b0;
   end

   // Carrier filter: reported level changes only after the minimum pulse
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dcd_cnt  <= 16'h0000;
         dcd_filt <= 1'b0;
      end else if (dcd_filt == !pins_s[1]) begin
         dcd_cnt <= 16'h0000;
      end else if (dcd_cnt == DCD_LAST) begin
         dcd_filt <= !pins_s[1];                               // [RULE4] [RULE5]
         dcd_cnt  <= 16'h0000;
      end else begin
         dcd_cnt <= dcd_cnt + 16'h0001;
      end
   end

   assign ext_live = '{brk: brk_live, cts: !pins_s[2], dcd: dcd_filt, sync: !pins_s[0]};

   // External/status latch follows live bits until an interrupt freezes it
   always_ff @(posedge sys_clk) begin
      if (chan_clr) begin
         ext_pend <= 1'b0;
         ext_lat  <= '0;
      end else if (!ext_pend && imr[acsi_pkg::IM_EXT_EN] && ext_live != ext_lat) begin
         ext_pend <= 1'b1;                                     // [RULE20] [RULE26]
         ext_lat  <= ext_live;                                 // [RULE1] [RULE2] [RULE4]
      end else if (cmd_ext) begin
         ext_pend <= 1'b0;                                     // [RULE3]
      end else if (!ext_pend) begin
         ext_lat <= ext_live;
      end
   end

   // Receive buffer with per-character flags
   assign full   = (cnt == FULL);
   assign push   = rx_char_valid && rx_run;
   assign pop    = reg_rd && (reg_addr == acsi_pkg::ADDR_DATA) && (cnt != '0) && !frozen;   // [RULE7]
   assign wr_idx = pop ? cnt - CW'(1) : (full ? FULL - CW'(1) : cnt);                       // [RULE9]

   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_ent
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               fifo[i] <= '0;
            end else if (push && wr_idx == CW'(i)) begin
               fifo[i]         <= rx_char;                     // [RULE25]
               fifo[i].overrun <= full && !pop;                // [RULE9] [RULE10]
            end else if (pop && i < DEPTH - 1) begin
               fifo[i] <= fifo[(i + 1) % DEPTH];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (chan_clr) cnt <= '0;
      else if (pop && !push) cnt <= cnt - CW'(1);              // [RULE11]
      else if (push && !pop && !full) cnt <= cnt + CW'(1);
   end

   // Latched parity and overrun; error reset loses to a new error
   always_ff @(posedge sys_clk) begin
      if (chan_clr) begin
         par_stk <= 1'b0;
         ovr_stk <= 1'b0;
      end else begin
         par_stk <= (pop && fifo[0].parity) || (par_stk && !cmd_err);    // [RULE23]
         ovr_stk <= (pop && fifo[0].overrun) || (ovr_stk && !cmd_err);
      end
   end

   assign head_err = (cnt != '0) && (fifo[0].framing || fifo[0].overrun ||
                     (fifo[0].parity && rx_mode != acsi_pkg::ACSI_RX_ALL_NOPAR));
   assign special  = head_err && rx_mode != acsi_pkg::ACSI_RX_OFF;                   // [RULE8]

   // First-character mode: arm, catch first character, freeze on error
   always_ff @(posedge sys_clk) begin
      if (chan_clr) begin
         first_arm  <= 1'b1;
         first_pend <= 1'b0;
         frozen     <= 1'b0;
         frz_rel    <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == acsi_pkg::ADDR_SPECIAL) first_arm <= 1'b1;
         else if (push) first_arm <= 1'b0;
         if (push && first_arm) first_pend <= 1'b1;
         else if (pop) first_pend <= 1'b0;
         // Error reset releases the held character until it is read
         if (special && rx_mode == acsi_pkg::ACSI_RX_FIRST && !frz_rel && !cmd_err) frozen <= 1'b1;   // [RULE7]
         else if (cmd_err) frozen <= 1'b0;
         if (cmd_err && frozen) frz_rel <= 1'b1;
         else if (pop) frz_rel <= 1'b0;
      end
   end

   assign rx_int = (cnt != '0 && (rx_mode == acsi_pkg::ACSI_RX_ALL || rx_mode == acsi_pkg::ACSI_RX_ALL_NOPAR))
                   || (first_pend && rx_mode == acsi_pkg::ACSI_RX_FIRST);

   // Transmit buffer and its empty interrupt
   assign tx_char_valid = tx_full && tx_run;
   assign handoff       = tx_char_valid && tx_char_ready;
   always_ff @(posedge sys_clk) begin
      if (chan_clr) begin
         tx_full <= 1'b0;
         tx_pend <= 1'b0;
         tx_char <= acsi_pkg::RST_BYTE;
      end else if (reg_wr && reg_addr == acsi_pkg::ADDR_DATA) begin
         tx_full <= 1'b1;
         tx_char <= reg_wdata;
         tx_pend <= 1'b0;
      end else begin
         if (handoff) tx_full <= 1'b0;
         if (handoff && imr[acsi_pkg::IM_TX_EN]) tx_pend <= 1'b1;                 // [RULE18]
         else if (cmd_txp) tx_pend <= 1'b0;
      end
   end

   // Vector modification by channel and cause
   assign sav     = CHAN_B ? imr[acsi_pkg::IM_SAV] : sav_in;                    // [RULE16]
   assign sav_out = imr[acsi_pkg::IM_SAV];
   always_comb begin
      if (special) cause = acsi_pkg::CAUSE_SPECIAL;                              // [RULE10]
      else if (rx_int) cause = acsi_pkg::CAUSE_RX;
      else if (tx_pend) cause = acsi_pkg::CAUSE_TX;
      else cause = acsi_pkg::CAUSE_EXT;
   end
   assign vector = sav ? {vbase[7:4], !CHAN_B, cause, vbase[0]} : vbase;        // [RULE14] [RULE15]

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         int_req    <= 1'b0;
         ack_valid  <= 1'b0;
         ack_vector <= acsi_pkg::RST_BYTE;
      end else begin
         int_req   <= special || rx_int || tx_pend || ext_pend;
         ack_valid <= int_ack;
         if (int_ack) ack_vector <= vector;                    // [RULE21]
      end
   end

   // Status images
   always_comb begin
      main_status = 8'h00;
      main_status[acsi_pkg::ST_RX_AVAIL] = (cnt != '0);                          // [RULE11]
      main_status[acsi_pkg::ST_INT_PEND] = int_req;
      main_status[acsi_pkg::ST_TX_EMPTY] = !tx_full;                             // [RULE12]
      main_status[acsi_pkg::ST_CARRIER]  = ext_lat.dcd;                          // [RULE5]
      main_status[acsi_pkg::ST_SYNC]     = ext_lat.sync;
      main_status[acsi_pkg::ST_CTS]      = ext_lat.cts;
      main_status[acsi_pkg::ST_BREAK]    = ext_lat.brk;                          // [RULE1]
      special_status = 8'h00;
      special_status[acsi_pkg::SR_ALL_SENT] = !tx_full && !tx_shift_busy;        // [RULE19]
      special_status[acsi_pkg::SR_PARITY]   = (cnt != '0 && fifo[0].parity) || par_stk;   // [RULE6]
      special_status[acsi_pkg::SR_OVERRUN]  = (cnt != '0 && fifo[0].overrun) || ovr_stk;
      special_status[acsi_pkg::SR_FRAMING]  = cnt != '0 && fifo[0].framing;      // [RULE24]
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            acsi_pkg::ADDR_STATUS:  reg_rdata <= main_status;
            acsi_pkg::ADDR_SPECIAL: reg_rdata <= special_status;
            acsi_pkg::ADDR_VECTOR:  reg_rdata <= vector;       // [RULE22]
            acsi_pkg::ADDR_DATA:    reg_rdata <= fifo[0].data;
            acsi_pkg::ADDR_CTRL:    reg_rdata <= {5'h00, ctrl};
            default:                reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Checks
   a_break_sets_bit: assert property (@(posedge sys_clk) disable iff (rst)   // [RULE1]
      $rose(brk_live) && imr[acsi_pkg::IM_EXT_EN] && !ext_pend && !chan_clr |=> ext_pend && ext_lat.brk)
      else $error("break start not latched");
   a_break_end_irq: assert property (@(posedge sys_clk) disable iff (rst)    // [RULE2]
      $fell(brk_live) && imr[acsi_pkg::IM_EXT_EN] && !ext_pend && !chan_clr |=> ext_pend && !ext_lat.brk)
      else $error("break end not reported");
   a_carrier_filter: assert property (@(posedge sys_clk) disable iff (rst)   // [RULE4]
      dcd_filt != !pins_s[1] && dcd_cnt == DCD_LAST |=> dcd_filt == $past(!pins_s[1]))
      else $error("carrier filter did not follow");
   a_overrun_overwrite: assert property (@(posedge sys_clk) disable iff (rst) // [RULE9]
      push && full && !pop && !chan_clr |=> cnt == FULL && fifo[DEPTH-1].overrun)
      else $error("overrun did not overwrite");
   a_frozen_holds: assert property (@(posedge sys_clk) disable iff (rst)     // [RULE7]
      frozen && !push && !chan_clr && !cmd_err ##0 reg_rd && reg_addr == acsi_pkg::ADDR_DATA |=> $stable(cnt))
      else $error("frozen character popped");
   a_tx_empty_read: assert property (@(posedge sys_clk) disable iff (rst)    // [RULE12]
      reg_rd && reg_addr == acsi_pkg::ADDR_STATUS |=> reg_rdata[acsi_pkg::ST_TX_EMPTY] == !$past(tx_full))
      else $error("tx empty bit wrong");
   a_special_vector: assert property (@(posedge sys_clk) disable iff (rst)   // [RULE8]
      int_ack && sav && special |=> ack_valid && ack_vector[2:1] == acsi_pkg::CAUSE_SPECIAL)
      else $error("special vector not returned");
   a_auto_cts_gate: assert property (@(posedge sys_clk) disable iff (rst)    // [RULE17]
      ctrl[acsi_pkg::CT_AUTO] && pins_s[2] |-> !tx_char_valid)
      else $error("transmit ran without cts");
   a_txint_after_empty: assert property (@(posedge sys_clk) disable iff (rst) // [RULE18]
      $rose(tx_pend) |-> $past(handoff))
      else $error("tx interrupt without emptying");
   c_break_cycle: cover property (@(posedge sys_clk) disable iff (rst) $rose(brk_live) ##[1:1000] $fell(brk_live));
   c_overrun: cover property (@(posedge sys_clk) disable iff (rst) push && full && !pop);
   c_freeze: cover property (@(posedge sys_clk) disable iff (rst) $rose(frozen));
   c_ack: cover property (@(posedge sys_clk) disable iff (rst) int_ack && sav ##1 ack_valid);
endmodule : acsi_channel
`default_nettype wire

// ==== acsi_line_model.sv ====
// Far-side serial line model: link clock and receive data.
// Assumes the bench raises frame around line activity and spacing for a break.
`timescale 1ns/1ps
`default_nettype none
module acsi_line_model (
   input  wire logic frame,
   input  wire logic spacing,
   output logic      link_clk,
   output logic      rxd
);
   initial begin
      link_clk = 1'b0;
      rxd = 1'b1;
      #13;
   end
   // Clock stands low outside frames; data moves on the low phase
   always begin
      #40 link_clk = 1'b0;
      rxd = ~spacing;
      #40 link_clk = frame;
   end
endmodule : acsi_line_model
`default_nettype wire

// ==== acsi_channel_tb.sv ====
// Self-checking bench for one async channel over its register port.
// Assumes acsi_pkg and the line model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module acsi_channel_tb;
   localparam logic [2:0] A_ST = acsi_pkg::ADDR_STATUS;
   localparam logic [2:0] A_SP = acsi_pkg::ADDR_SPECIAL;
   localparam logic [2:0] A_VE = acsi_pkg::ADDR_VECTOR;
   localparam logic [2:0] A_DA = acsi_pkg::ADDR_DATA;
   localparam logic [2:0] A_CT = acsi_pkg::ADDR_CTRL;
   logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, int_ack = 1'b0, rx_char_valid = 1'b0;
   logic tx_char_ready = 1'b0, cts_in_n = 1'b0, carrier_detect_in_n = 1'b0, frame = 1'b0, spacing = 1'b0;
   logic tx_shift_busy = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, ack_vector, tx_char;
   logic ack_valid, int_req, link_clk, rxd, tx_char_valid;
   acsi_pkg::acsi_rxent_t rx_char = '0;
   int err_total = 0, n_tests = 0;
   always #2.5 sys_clk = ~sys_clk;
   acsi_line_model acsi_line_model_inst (.frame(frame), .spacing(spacing), .link_clk(link_clk), .rxd(rxd));
   acsi_channel #(.CHAN_B(1'b1), .DCD_CYCLES(2), .BRK_EDGES(3)) acsi_channel_inst (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_ack(int_ack), .ack_vector(ack_vector),
      .ack_valid(ack_valid), .int_req(int_req), .sav_in(1'b0), .sav_out(), .rx_clk_pin(link_clk),
      .rxd_pin(rxd), .cts_in_n(cts_in_n), .carrier_detect_in_n(carrier_detect_in_n), .sync_in_n(1'b1),
      .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_run(), .rx_search_hold(),
      .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready), .tx_char(tx_char),
      .tx_shift_busy(tx_shift_busy), .tx_run());
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read, mask, compare in the single cycle the data stands
   task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", reg_rdata & m, e);
   endtask : rdc
   task automatic push(input logic [7:0] d, input logic par);
      @(posedge sys_clk);
      rx_char <= '{data: d, framing: 1'b0, overrun: 1'b0, parity: par};
      rx_char_valid <= 1'b1;
      @(posedge sys_clk);
      rx_char_valid <= 1'b0;
   endtask : push
   task automatic ack(input logic [7:0] e);
      @(posedge sys_clk);
      int_ack <= 1'b1;
      @(posedge sys_clk);
      int_ack <= 1'b0;
      #1 chk("ack_valid", {7'h00, ack_valid}, 8'h01);
      chk("ack_vector", ack_vector, e);
   endtask : ack
   task automatic report_and_stop();
      if (err_total == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #200000;
      err_total++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      rdc(A_ST, 8'h05, 8'h04);
      repeat (4) @(posedge sys_clk);
      rdc(A_ST, 8'h08, 8'h08);
      wr(A_CT, 8'h01);
      push(8'hA1, 1'b0);
      push(8'hA2, 1'b0);
      push(8'hA3, 1'b0);
      push(8'hA4, 1'b0);
      rdc(A_ST, 8'h01, 8'h01);
      rdc(A_DA, 8'hFF, 8'hA1);
      rdc(A_DA, 8'hFF, 8'hA2);
      rdc(A_SP, 8'h20, 8'h20);
      rdc(A_DA, 8'hFF, 8'hA4);
      rdc(A_ST, 8'h01, 8'h00);
      wr(A_ST, 8'h30);
      rdc(A_SP, 8'h30, 8'h00);
      wr(A_VE, 8'hF0);
      wr(A_SP, 8'h1C);
      push(8'h5A, 1'b1);
      repeat (4) @(posedge sys_clk);
      ack(8'hF6);
      rdc(A_VE, 8'hFF, 8'hF6);
      rdc(A_SP, 8'h10, 8'h10);
      rdc(A_DA, 8'hFF, 8'h5A);
      wr(A_ST, 8'h30);
      push(8'h3C, 1'b0);
      repeat (4) @(posedge sys_clk);
      ack(8'hF4);
      rdc(A_DA, 8'hFF, 8'h3C);
      wr(A_SP, 8'h08);
      push(8'h66, 1'b1);
      rdc(A_DA, 8'hFF, 8'h66);
      rdc(A_ST, 8'h01, 8'h01);
      wr(A_ST, 8'h30);
      rdc(A_DA, 8'hFF, 8'h66);
      rdc(A_ST, 8'h01, 8'h00);
      wr(A_SP, 8'h01);
      wr(A_ST, 8'h10);
      frame <= 1'b1;
      spacing <= 1'b1;
      repeat (100) @(posedge sys_clk);
      rdc(A_ST, 8'h80, 8'h80);
      chk("int_req", {7'h00, int_req}, 8'h01);
      wr(A_ST, 8'h10);
      spacing <= 1'b0;
      repeat (60) @(posedge sys_clk);
      frame <= 1'b0;
      rdc(A_ST, 8'h80, 8'h00);
      chk("int_req", {7'h00, int_req}, 8'h01);
      wr(A_ST, 8'h10);
      repeat (3) @(posedge sys_clk);
      #1 chk("int_req", {7'h00, int_req}, 8'h00);
      carrier_detect_in_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      #1 chk("int_req", {7'h00, int_req}, 8'h01);
      rdc(A_ST, 8'h08, 8'h00);
      wr(A_ST, 8'h10);
      wr(A_SP, 8'h02);
      cts_in_n <= 1'b1;
      tx_shift_busy <= 1'b1;
      wr(A_CT, 8'h07);
      wr(A_DA, 8'hA5);
      repeat (4) @(posedge sys_clk);
      cts_in_n <= 1'b0;
      #1 chk("tx_char_valid", {7'h00, tx_char_valid}, 8'h00);
      chk("int_req", {7'h00, int_req}, 8'h00);
      for (int i = 0; i < 20 && tx_char_valid !== 1'b1; i++) @(posedge sys_clk);
      chk("tx_char", tx_char, 8'hA5);
      @(posedge sys_clk);
      tx_char_ready <= 1'b1;
      @(posedge sys_clk);
      tx_char_ready <= 1'b0;
      rdc(A_SP, 8'h01, 8'h00);
      chk("int_req", {7'h00, int_req}, 8'h01);
      tx_shift_busy <= 1'b0;
      rdc(A_SP, 8'h01, 8'h01);
      rdc(A_ST, 8'h04, 8'h04);
      report_and_stop();
   end
endmodule : acsi_channel_tb
`default_nettype wire
